// >>> io_order_if.sv
// carrier between the selector and its io ordering queue
`timescale 1ns/100ps
interface io_order_if #(parameter int TAG_W = 6);
  logic             ce;
  logic             arrive;
  logic [TAG_W-1:0] arrive_tag;
  logic             leave;
  logic [TAG_W-1:0] leave_tag;
  logic             alloc_seen;
  logic             order_err;
  logic [7:0]       occupancy;

  modport top   (output ce, arrive, arrive_tag, leave, leave_tag,
                 input  alloc_seen, order_err, occupancy);
  modport queue (input  ce, arrive, arrive_tag, leave, leave_tag,
                 output alloc_seen, order_err, occupancy);
endinterface

// >>> io_ordering_queue.sv
// in-order queue of io request tags kept beside the request queue
`timescale 1ns/100ps
module io_ordering_queue
  import ring_event_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int TAG_W = 6
) (
  input wire logic clk,
  input wire logic rst_b,
  io_order_if.queue q
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [TAG_W-1:0] tag_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [CW-1:0]    count_q;

  wire full     = (count_q == CW'(DEPTH));
  wire empty    = (count_q == '0);
  // an arrival into a full queue is dropped and not counted
  wire push     = q.arrive & ~full;
  wire pop      = q.leave & ~empty;
  wire mismatch = pop & (tag_q[rd_ptr_q] != q.leave_tag);
  wire [PW-1:0] wr_next = (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
  wire [PW-1:0] rd_next = (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;

  assign q.alloc_seen = push;
  assign q.order_err  = mismatch;
  assign q.occupancy  = 8'(count_q);

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          tag_q[i] <= '0;
        end else if (q.ce && push && wr_ptr_q == PW'(i)) begin
          tag_q[i] <= q.arrive_tag;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else if (q.ce) begin
      if (push) wr_ptr_q <= wr_next;
      if (pop) rd_ptr_q <= rd_next;
      count_q <= count_q + CW'(push) - CW'(pop);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_order_grow: assert property (q.ce && push && !pop |=> count_q == $past(count_q) + 1'b1)
    else $error("io ordering queue did not grow on arrival");
  chk_order_head: assert property (q.ce && pop |=> rd_ptr_q != $past(rd_ptr_q) || DEPTH == 1)
    else $error("io ordering queue head did not advance on leave");
endmodule

// >>> ring_event_map.svh
// offsets, field positions, codes and reset values of the ring and ingress event selector
`ifndef RING_EVENT_MAP_SVH
`define RING_EVENT_MAP_SVH

// ----------------------------------------------------------------------------
// event codes
// ----------------------------------------------------------------------------
`define EVT_REQ_RING_USE        8'h1b
`define EVT_ACK_RING_USE        8'h1c
`define EVT_DATA_RING_USE       8'h1d
`define EVT_INVALIDATE_RING_USE 8'h1e
`define EVT_RING_BOUNCE         8'h05
`define EVT_RING_SRC_THROTTLE   8'h07
`define EVT_INGRESS_STARVE      8'h12
`define EVT_INGRESS_ALLOC       8'h13
`define EVT_PROBE_RETRY         8'h31

// ----------------------------------------------------------------------------
// umask bit positions
// ----------------------------------------------------------------------------
`define UM_UP_EVEN          0
`define UM_UP_ODD           1
`define UM_DOWN_EVEN        2
`define UM_DOWN_ODD         3
`define UM_ANY_POLARITY     8'h0f
`define UM_CORE_ACK_BOUNCE  1
`define UM_CORE_DATA_BOUNCE 2
`define UM_CORE_SNOOP_BOUNCE 3
`define UM_REQ_STARVED      0
`define UM_PROBE_STARVED    1
`define UM_RESP_STARVED     2
`define UM_RESP_BIDS        3
`define UM_ALLOC_REQ        0
`define UM_ALLOC_REJECTED   1
`define UM_ALLOC_PROBE      2
`define UM_ALLOC_IO         4
`define UM_RETRY_ANY        0
`define UM_RETRY_FULL       1
`define UM_RETRY_CONFLICT   2
`define UM_RETRY_CREDIT     4

// ----------------------------------------------------------------------------
// counters and egress indices
// ----------------------------------------------------------------------------
`define NUM_COUNTERS        4
`define RING_CNT_LO         2
`define OTHER_CNT_HI        1
`define EGR_REQ             0
`define EGR_DATA            1
`define EGR_ACK             2

// ----------------------------------------------------------------------------
// register word indices (byte address = 4 * index) and fields
// ----------------------------------------------------------------------------
`define IDX_CTRL            3'h0
`define IDX_SEL0            3'h1
`define IDX_STATUS          3'h5
`define CTRL_EN_BIT         0
`define STAT_ERR_BIT        8
`define SLICE_TOTAL_RESET   4'h8

`endif

// >>> ring_event_pkg.sv
// types shared by the ring and ingress event selector
package ring_event_pkg;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } bus_state_t;

  typedef struct packed {
    logic [7:0] umask;
    logic [7:0] code;
  } sel_t;

  typedef logic [3:0] pol_t;
endpackage

// >>> ring_ingress_event_select.sv
// ring stop and ingress queue event qualification for one cache slice monitor
//
// What this block does
// - request ring use counts only in counters 2-3
// - pass or sink counts, own send does not
// - umask bits pick up/down, even/odd polarity
// - ack ring use, own code, counters 2-3
// - data ring use, own code, counters 2-3
// - ring side swaps up and down meaning
// - bounce event picks ack, data, snoop bounces
// - invalidate ring use, single ring, counters 2-3
// - source throttle counts only in counters 0-1
// - starvation event counts in counters 0-1
// - starvation umask picks which queue starves
// - allocation event picks request, probe, io queue
// - io requests kept in arrival order
// - probe retry event counts in counters 0-1
// - retry umask picks any, full, conflict, credit
// - needed full egress makes probe retry
`timescale 1ns/100ps
`include "ring_event_map.svh"
module ring_ingress_event_select
  import ring_event_pkg::*;
#(
  parameter int IO_DEPTH = 8,
  parameter int TAG_W    = 6
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             ce,
  input  wire logic [4:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output wire logic [31:0]      avs_readdata,
  output wire logic             avs_waitrequest,
  input  wire logic [3:0]       req_ring_pass,
  input  wire logic [3:0]       req_ring_sink,
  input  wire logic [3:0]       req_ring_send,
  input  wire logic [3:0]       ack_ring_pass,
  input  wire logic [3:0]       ack_ring_sink,
  input  wire logic [3:0]       ack_ring_send,
  input  wire logic [3:0]       data_ring_pass,
  input  wire logic [3:0]       data_ring_sink,
  input  wire logic [3:0]       data_ring_send,
  input  wire logic [3:0]       invalidate_ring_pass,
  input  wire logic [3:0]       invalidate_ring_sink,
  input  wire logic [3:0]       invalidate_ring_send,
  input  wire logic             core_ack_bounce,
  input  wire logic             core_data_bounce,
  input  wire logic             core_snoop_bounce,
  input  wire logic             ring_src_throttle,
  input  wire logic             req_queue_starved,
  input  wire logic             probe_queue_starved,
  input  wire logic             response_queue_starved,
  input  wire logic             response_queue_bids,
  input  wire logic             req_queue_alloc,
  input  wire logic             req_queue_rejected,
  input  wire logic             probe_queue_alloc,
  input  wire logic             io_req_arrive,
  input  wire logic [TAG_W-1:0] io_req_arrive_tag,
  input  wire logic             io_req_leave,
  input  wire logic [TAG_W-1:0] io_req_leave_tag,
  input  wire logic             probe_try,
  input  wire logic [2:0]       probe_egress_need,
  input  wire logic [2:0]       egress_full,
  input  wire logic             probe_addr_conflict,
  input  wire logic             link_credit_shortage,
  output wire logic [3:0]       counter_inc
);

  // --------------------------------------------------------------------------
  // register state
  // --------------------------------------------------------------------------
  bus_state_t  bus_state_q;
  bus_state_t  bus_state_d;
  logic        waitrequest_q;
  logic [31:0] readdata_q;
  logic        en_q;
  logic [3:0]  slice_idx_q;
  logic [3:0]  slice_total_q;
  sel_t        sel_q [`NUM_COUNTERS];
  logic        order_err_q;
  logic        order_err_d;
  logic [3:0]  inc_q;

  io_order_if #(.TAG_W(TAG_W)) io_bus ();

  io_ordering_queue #(
    .DEPTH (IO_DEPTH),
    .TAG_W (TAG_W)
  ) u_io_queue (
    .clk   (clk),
    .rst_b (rst_b),
    .q     (io_bus)
  );

  assign io_bus.ce         = ce;
  assign io_bus.arrive     = io_req_arrive;
  assign io_bus.arrive_tag = io_req_arrive_tag;
  assign io_bus.leave      = io_req_leave;
  assign io_bus.leave_tag  = io_req_leave_tag;

  // --------------------------------------------------------------------------
  // avalon slave decode
  // --------------------------------------------------------------------------
  wire [2:0]  reg_idx    = avs_address[4:2];
  wire        bus_req    = avs_read | avs_write;
  // the write lands on the edge where the master sees waitrequest low
  wire        wr_commit  = (bus_state_q == BUS_DONE) & avs_write;
  wire        ctrl_wr    = wr_commit & (reg_idx == `IDX_CTRL);
  wire        status_wr  = wr_commit & (reg_idx == `IDX_STATUS);
  wire        sel_range  = (reg_idx >= `IDX_SEL0) && (reg_idx < `IDX_SEL0 + `NUM_COUNTERS);
  wire [2:0]  sel_idx    = reg_idx - `IDX_SEL0;
  wire [31:0] ctrl_word  = {16'h0, slice_total_q, slice_idx_q, 7'h0, en_q};
  wire [31:0] stat_word  = {8'h0, io_bus.occupancy, 7'h0, order_err_q, 4'h0, inc_q};
  wire [31:0] sel_word   = sel_range ? {16'h0, sel_q[sel_idx[1:0]]} : 32'h0;
  wire [31:0] rd_word    = (reg_idx == `IDX_CTRL)   ? ctrl_word :
                           (reg_idx == `IDX_STATUS) ? stat_word : sel_word;
  // status error bit is write one to clear; a new mismatch in the same cycle wins
  wire        err_clr    = status_wr & avs_byteenable[1] & avs_writedata[`STAT_ERR_BIT];

  always_comb begin
    bus_state_d = bus_state_q;
    unique case (bus_state_q)
      BUS_IDLE: begin
        if (bus_req) bus_state_d = BUS_DONE;
      end
      BUS_DONE: begin
        bus_state_d = BUS_IDLE;
      end
      default: begin
        bus_state_d = BUS_IDLE;
      end
    endcase
  end

  assign order_err_d = (order_err_q & ~err_clr) | io_bus.order_err;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bus_state_q   <= BUS_IDLE;
      waitrequest_q <= 1'b1;
      readdata_q    <= 32'h0;
    end else if (ce) begin
      bus_state_q   <= bus_state_d;
      waitrequest_q <= (bus_state_d != BUS_DONE);
      if (bus_state_q == BUS_IDLE && avs_read) readdata_q <= rd_word;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      en_q          <= 1'b0;
      slice_idx_q   <= 4'h0;
      slice_total_q <= `SLICE_TOTAL_RESET;
      order_err_q   <= 1'b0;
    end else if (ce) begin
      if (ctrl_wr && avs_byteenable[0]) en_q <= avs_writedata[`CTRL_EN_BIT];
      if (ctrl_wr && avs_byteenable[1]) begin
        slice_idx_q   <= avs_writedata[11:8];
        slice_total_q <= avs_writedata[15:12];
      end
      order_err_q <= order_err_d;
    end
  end

  assign avs_readdata    = readdata_q;
  assign avs_waitrequest = waitrequest_q;

  // --------------------------------------------------------------------------
  // ring side and polarity labels
  // --------------------------------------------------------------------------
  // physical polarity bits: 0 cw even, 1 cw odd, 2 ccw even, 3 ccw odd
  // slices in the first half sit on the left side, where up is clockwise
  wire left_side = {1'b0, slice_idx_q, 1'b0} < {2'h0, slice_total_q};

  function automatic pol_t to_label(input pol_t phys, input logic left);
    to_label = left ? phys : {phys[1:0], phys[3:2]};
  endfunction

  // a slot the stop injects into is not a pass-through or a sink
  wire [3:0] req_used  = (req_ring_pass | req_ring_sink) & ~req_ring_send;
  wire [3:0] ack_used  = (ack_ring_pass | ack_ring_sink) & ~ack_ring_send;
  wire [3:0] data_used = (data_ring_pass | data_ring_sink) & ~data_ring_send;
  wire [3:0] inv_used  = (invalidate_ring_pass | invalidate_ring_sink) & ~invalidate_ring_send;
  wire [3:0] req_lab   = to_label(req_used, left_side);
  wire [3:0] ack_lab   = to_label(ack_used, left_side);
  wire [3:0] data_lab  = to_label(data_used, left_side);

  // --------------------------------------------------------------------------
  // per event condition vectors, one bit per umask bit
  // --------------------------------------------------------------------------
  wire probe_full = probe_try & |(probe_egress_need & egress_full);
  wire probe_any  = probe_full | probe_addr_conflict;

  logic [7:0] req_v;
  logic [7:0] ack_v;
  logic [7:0] data_v;
  logic [7:0] inv_v;
  logic [7:0] bounce_v;
  logic [7:0] starve_v;
  logic [7:0] alloc_v;
  logic [7:0] retry_v;

  always_comb begin
    req_v    = {4'h0, req_lab};
    ack_v    = {4'h0, ack_lab};
    data_v   = {4'h0, data_lab};
    // one invalidate ring only: polarity bits are taken as they arrive
    inv_v    = {4'h0, inv_used};
    bounce_v = 8'h0;
    bounce_v[`UM_CORE_ACK_BOUNCE]   = core_ack_bounce;
    bounce_v[`UM_CORE_DATA_BOUNCE]  = core_data_bounce;
    bounce_v[`UM_CORE_SNOOP_BOUNCE] = core_snoop_bounce;
    starve_v = 8'h0;
    starve_v[`UM_REQ_STARVED]   = req_queue_starved;
    starve_v[`UM_PROBE_STARVED] = probe_queue_starved;
    starve_v[`UM_RESP_STARVED]  = response_queue_starved;
    starve_v[`UM_RESP_BIDS]     = response_queue_bids;
    alloc_v  = 8'h0;
    alloc_v[`UM_ALLOC_REQ]      = req_queue_alloc;
    alloc_v[`UM_ALLOC_REJECTED] = req_queue_rejected;
    alloc_v[`UM_ALLOC_PROBE]    = probe_queue_alloc;
    alloc_v[`UM_ALLOC_IO]       = io_bus.alloc_seen;
    retry_v  = 8'h0;
    retry_v[`UM_RETRY_ANY]      = probe_any;
    retry_v[`UM_RETRY_FULL]     = probe_full;
    retry_v[`UM_RETRY_CONFLICT] = probe_addr_conflict;
    retry_v[`UM_RETRY_CREDIT]   = link_credit_shortage;
  end

  // --------------------------------------------------------------------------
  // per counter select, restriction and increment
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `NUM_COUNTERS; g++) begin : g_cnt
      wire [7:0] code    = sel_q[g].code;
      wire [7:0] umask   = sel_q[g].umask;
      wire       is_ring = (code == `EVT_REQ_RING_USE) || (code == `EVT_ACK_RING_USE) ||
                           (code == `EVT_DATA_RING_USE) || (code == `EVT_INVALIDATE_RING_USE);
      // ring use events live only in the upper counters, all others in the lower
      wire       allowed = is_ring ? (g >= `RING_CNT_LO) : (g <= `OTHER_CNT_HI);
      wire [7:0] cond    = (code == `EVT_REQ_RING_USE)        ? req_v    :
                           (code == `EVT_ACK_RING_USE)        ? ack_v    :
                           (code == `EVT_DATA_RING_USE)       ? data_v   :
                           (code == `EVT_INVALIDATE_RING_USE) ? inv_v    :
                           (code == `EVT_RING_BOUNCE)         ? bounce_v :
                           (code == `EVT_RING_SRC_THROTTLE)   ? {8{ring_src_throttle}} :
                           (code == `EVT_INGRESS_STARVE)      ? starve_v :
                           (code == `EVT_INGRESS_ALLOC)       ? alloc_v  :
                           (code == `EVT_PROBE_RETRY)         ? retry_v  : 8'h0;
      // throttle has no sub-selection, so its umask is ignored
      wire [7:0] eff_mask = (code == `EVT_RING_SRC_THROTTLE) ? 8'hff : umask;
      wire       hit      = en_q & allowed & |(cond & eff_mask);

      always_ff @(posedge clk) begin
        if (!rst_b) begin
          sel_q[g] <= '0;
        end else if (ce && wr_commit && sel_range && sel_idx == 3'(g)) begin
          if (avs_byteenable[0]) sel_q[g].code  <= avs_writedata[7:0];
          if (avs_byteenable[1]) sel_q[g].umask <= avs_writedata[15:8];
        end
      end

      always_ff @(posedge clk) begin
        if (!rst_b) begin
          inc_q[g] <= 1'b0;
        end else if (ce) begin
          inc_q[g] <= hit;
        end
      end
    end
  endgenerate

  assign counter_inc = inc_q;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_bus_req;
    ce && bus_req && bus_state_q == BUS_IDLE;
  endsequence
  sequence s_bus_ack;
    !waitrequest_q ##1 waitrequest_q;
  endsequence

  chk_bus_wait_state: assert property (s_bus_req ##1 ce |-> s_bus_ack)
    else $error("bus answer not exactly one wait state");
  chk_req_ring_restrict: assert property (ce && sel_q[0].code == `EVT_REQ_RING_USE |=> !inc_q[0])
    else $error("request ring use counted in a low counter");
  chk_ack_ring_count: assert property (ce && en_q && sel_q[2].code == `EVT_ACK_RING_USE &&
      sel_q[2].umask == `UM_ANY_POLARITY && |ack_used |=> inc_q[2])
    else $error("ack ring use missed");
  chk_send_excluded: assert property (ce && sel_q[2].code == `EVT_ACK_RING_USE &&
      ((ack_ring_pass | ack_ring_sink) & ~ack_ring_send) == 4'h0 |=> !inc_q[2])
    else $error("ack ring counted for own send");
  chk_side_swap: assert property (ce && en_q && !left_side &&
      sel_q[2].code == `EVT_DATA_RING_USE && sel_q[2].umask == 8'h01 && data_used == 4'h4
      |=> inc_q[2])
    else $error("right side up even did not follow ccw ring");
  chk_bounce_select: assert property (ce && en_q && sel_q[0].code == `EVT_RING_BOUNCE &&
      sel_q[0].umask == 8'h0e
      |=> inc_q[0] == $past(core_ack_bounce | core_data_bounce | core_snoop_bounce))
    else $error("core bounce selection wrong");
  chk_throttle_low: assert property (ce && sel_q[3].code == `EVT_RING_SRC_THROTTLE |=> !inc_q[3])
    else $error("throttle counted in a high counter");
  chk_starve_or: assert property (ce && en_q && sel_q[1].code == `EVT_INGRESS_STARVE &&
      sel_q[1].umask == 8'h0a |=> inc_q[1] == $past(probe_queue_starved | response_queue_bids))
    else $error("starvation umask bits not or-ed");
  chk_io_alloc: assert property (ce && en_q && sel_q[0].code == `EVT_INGRESS_ALLOC &&
      sel_q[0].umask == 8'h10 && io_req_arrive && io_bus.occupancy == 8'h0 |=> inc_q[0])
    else $error("io ordering allocation missed");
  chk_probe_full: assert property (ce && en_q && sel_q[0].code == `EVT_PROBE_RETRY &&
      sel_q[0].umask == 8'h02 && probe_try && (probe_egress_need & egress_full) != 3'h0
      |=> inc_q[0])
    else $error("full egress probe retry missed");
endmodule

// >>> slice_far_side.sv
// model of the ring stop and ingress queues facing the selector
`timescale 1ns/100ps
module slice_far_side (
  output logic [3:0] req_ring_pass, req_ring_sink, req_ring_send,
  output logic [3:0] ack_ring_pass, ack_ring_sink, ack_ring_send,
  output logic [3:0] data_ring_pass, data_ring_sink, data_ring_send,
  output logic [3:0] invalidate_ring_pass, invalidate_ring_sink, invalidate_ring_send,
  output logic       core_ack_bounce, core_data_bounce, core_snoop_bounce,
  output logic       ring_src_throttle, req_queue_starved, probe_queue_starved,
  output logic       response_queue_starved, response_queue_bids, req_queue_alloc,
  output logic       req_queue_rejected, probe_queue_alloc, io_req_arrive,
  output logic       io_req_leave, probe_try, probe_addr_conflict, link_credit_shortage,
  output logic [5:0] io_req_arrive_tag, io_req_leave_tag,
  output logic [2:0] probe_egress_need, egress_full
);
  // every level lasts one cycle: the bench drops all of them after each event edge
  task automatic idle;
    {req_ring_pass, req_ring_sink, req_ring_send, ack_ring_pass, ack_ring_sink,
     ack_ring_send, data_ring_pass, data_ring_sink, data_ring_send, invalidate_ring_pass,
     invalidate_ring_sink, invalidate_ring_send, core_ack_bounce, core_data_bounce,
     core_snoop_bounce, ring_src_throttle, req_queue_starved, probe_queue_starved,
     response_queue_starved, response_queue_bids, req_queue_alloc, req_queue_rejected,
     probe_queue_alloc, io_req_arrive, io_req_leave, probe_try, probe_addr_conflict,
     link_credit_shortage, io_req_arrive_tag, io_req_leave_tag, probe_egress_need,
     egress_full} <= '0;
  endtask
  initial idle();
endmodule

// >>> tb_top.sv
// self-checking bench for the ring and ingress event selector
`timescale 1ns/100ps
module tb_top;
  logic        clk, rst_b, ce, avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0]  avs_byteenable, counter_inc;
  logic [3:0]  req_ring_pass, req_ring_sink, req_ring_send, ack_ring_pass, ack_ring_sink;
  logic [3:0]  ack_ring_send, data_ring_pass, data_ring_sink, data_ring_send;
  logic [3:0]  invalidate_ring_pass, invalidate_ring_sink, invalidate_ring_send;
  logic        core_ack_bounce, core_data_bounce, core_snoop_bounce, ring_src_throttle;
  logic        req_queue_starved, probe_queue_starved, response_queue_starved;
  logic        response_queue_bids, req_queue_alloc, req_queue_rejected, probe_queue_alloc;
  logic        io_req_arrive, io_req_leave, probe_try, probe_addr_conflict;
  logic        link_credit_shortage;
  logic [5:0]  io_req_arrive_tag, io_req_leave_tag;
  logic [2:0]  probe_egress_need, egress_full;
  int          n_fail = 0;
  int          n_compared = 0;

  ring_ingress_event_select uut (.*);
  slice_far_side far (.*);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // bus, event and verdict tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // hold the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // counter_inc follows the sampled inputs by one edge; read it mid-cycle while it stands
  task automatic fire(input string nm, input logic [3:0] e);
    @(posedge clk);
    far.idle();
    @(negedge clk);
    chk(nm, {28'h0, e}, {28'h0, counter_inc});
    @(posedge clk);
  endtask

  task automatic give_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h3;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    bus(0, 5'h00, 32'h0);
    chk("ctrl reset", 32'h0000_8000, q);
    bus(0, 5'h18, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("test registers done");
    bus(1, 5'h00, 32'h0000_8001);
    bus(1, 5'h04, 32'h0000_0f1b);
    bus(1, 5'h08, 32'h0000_0f1c);
    bus(1, 5'h0c, 32'h0000_0f1c);
    bus(1, 5'h10, 32'h0000_0f1b);
    far.ack_ring_pass <= 4'h5;
    fire("ack pass", 4'h4);
    far.ack_ring_pass <= 4'h1;
    far.ack_ring_send <= 4'h1;
    fire("ack own send", 4'h0);
    far.req_ring_sink <= 4'h2;
    fire("req sink", 4'h8);
    bus(1, 5'h0c, 32'h0000_011d);
    far.data_ring_pass <= 4'h1;
    fire("left up even", 4'h4);
    far.data_ring_pass <= 4'h4;
    fire("left down even", 4'h0);
    bus(1, 5'h00, 32'h0000_8401);
    far.data_ring_pass <= 4'h4;
    fire("right up even", 4'h4);
    far.data_ring_pass <= 4'h1;
    fire("right down even", 4'h0);
    bus(1, 5'h10, 32'h0000_0f1e);
    far.invalidate_ring_sink <= 4'h8;
    fire("inval sink", 4'h8);
    $display("test ring use done");
    bus(1, 5'h04, 32'h0000_0e05);
    bus(1, 5'h08, 32'h0000_0007);
    bus(1, 5'h0c, 32'h0000_0f05);
    bus(1, 5'h10, 32'h0000_0007);
    far.core_snoop_bounce <= 1'b1;
    far.ring_src_throttle <= 1'b1;
    fire("bounce throttle", 4'h3);
    far.core_ack_bounce <= 1'b1;
    fire("ack bounce", 4'h1);
    bus(1, 5'h04, 32'h0000_0512);
    bus(1, 5'h08, 32'h0000_0a12);
    far.probe_queue_starved <= 1'b1;
    fire("probe starved", 4'h2);
    far.response_queue_starved <= 1'b1;
    fire("resp starved", 4'h1);
    bus(1, 5'h04, 32'h0000_1013);
    bus(1, 5'h08, 32'h0000_0513);
    far.io_req_arrive <= 1'b1;
    far.io_req_arrive_tag <= 6'h03;
    fire("io alloc", 4'h1);
    far.probe_queue_alloc <= 1'b1;
    fire("probe alloc", 4'h2);
    $display("test ingress done");
    bus(1, 5'h04, 32'h0000_0231);
    bus(1, 5'h08, 32'h0000_1531);
    far.probe_try <= 1'b1;
    far.probe_egress_need <= 3'h1;
    far.egress_full <= 3'h1;
    fire("egress full", 4'h3);
    far.probe_try <= 1'b1;
    far.probe_egress_need <= 3'h2;
    far.egress_full <= 3'h1;
    fire("unneeded full", 4'h0);
    far.probe_try <= 1'b1;
    far.link_credit_shortage <= 1'b1;
    fire("credit", 4'h2);
    far.io_req_leave <= 1'b1;
    far.io_req_leave_tag <= 6'h03;
    fire("io leave", 4'h0);
    far.io_req_arrive <= 1'b1;
    far.io_req_arrive_tag <= 6'h01;
    fire("io arrive 1", 4'h0);
    far.io_req_arrive <= 1'b1;
    far.io_req_arrive_tag <= 6'h02;
    fire("io arrive 2", 4'h0);
    far.io_req_leave <= 1'b1;
    far.io_req_leave_tag <= 6'h02;
    fire("io out of order", 4'h0);
    bus(0, 5'h14, 32'h0);
    chk("order error", 32'h0001_0100, q);
    bus(1, 5'h14, 32'h0000_0100);
    bus(0, 5'h14, 32'h0);
    chk("error cleared", 32'h0001_0000, q);
    $display("test retry and order done");
    give_verdict();
  end
endmodule
